// File: design/pic_consts.svh
// constants for the pipeline interlock and exception controller
// assumes a five stage pipeline on one processor clock
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
`define PIC_REG_AW        5
`define PIC_EXC_W         5
`define PIC_BYP_FILE      2'h0
`define PIC_BYP_EX        2'h1
`define PIC_BYP_DC        2'h2
`define PIC_STORE_HOLD    1
`define PIC_EXC_ADDR_ERR_F 5'h04
`define PIC_EXC_INT        5'h00
`define PIC_EXC_NMI        5'h1e
`define PIC_EXC_TLB_I      5'h02
`define PIC_EXC_BUS_I      5'h06
`define PIC_EXC_SYSCALL    5'h08
`define PIC_EXC_BREAK      5'h09
`define PIC_EXC_RESERVED_INSTR_EXC       5'h0a
`define PIC_EXC_COPU       5'h0b
`define PIC_EXC_OVF        5'h0c
`define PIC_EXC_TRAP       5'h0d
`define PIC_EXC_PARITY     5'h10
`define PIC_EXC_ADDR_ERR_D 5'h05
`define PIC_EXC_RESET      5'h1f
`define PIC_EXC_TLB_D      5'h03
`define PIC_EXC_TLB_MOD    5'h01
`define PIC_EXC_WATCH      5'h17
`define PIC_EXC_BUS_D      5'h07
`endif

// File: design/pic_pkg.sv
// types for the pipeline interlock and exception controller
// assumes pic_consts.svh supplies the numeric values
`include "pic_consts.svh"
package pic_pkg;
  typedef logic [`PIC_REG_AW-1:0] pic_reg_t;
  typedef logic [`PIC_EXC_W-1:0]  pic_exc_t;
  typedef logic [1:0]             pic_byp_t;
  typedef enum logic [2:0] {
    PIC_RUN   = 3'h1,
    PIC_STALL = 3'h2,
    PIC_SLIP  = 3'h4
  } pic_mode_t;
endpackage

// File: design/pic_ctrl.sv
// pipeline interlock, slip, exception and bypass control
// assumes fetch valid bit and hazard inputs on clk_sys; later stage valid bits are kept here
//
// Notes on behaviour
// - check all faults every cycle, all stages
// - each fault tied to one fixed stage
// - exceptions detected in their own stages
// - fault kills itself and younger, hides their faults
// - write-back commits exception, redirects, clears earlier
// - precise, in order, older fault wins
// - stalls freeze pipe, resume losing nothing
// - dirty victim to write buffer next cycle
// - miss stall ends after last refill word
// - cache op in data stage stalls till done
// - issue only when operands, resources ready
// - slip lets back end advance, inserts bubbles
// - killed instructions never cause slips
// - load or move-from use slips until data
// - move-from hi/lo waits for mul/div done
// - store then load slips one clock
// - sysctl config/status write slips one clock
// - bypass only into register-read stage
// - bypass unit drives register file addresses
// - store holds data cache, next user stalls
`timescale 1ns/100ps
module pic_ctrl
  import pic_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             fetch_valid,
  input  wire logic             rr_valid,
  input  wire logic             fetch_address_error,
  input  wire logic             nmi_req,
  input  wire logic             fetch_translation_exc,
  input  wire logic             fetch_parity_error,
  input  wire logic             external_interrupt,
  input  wire logic             fetch_bus_error,
  input  wire logic             system_call_exc,
  input  wire logic             breakpoint_exc,
  input  wire logic             coproc_unusable_exc,
  input  wire logic             reserved_instr_exc,
  input  wire logic             trap_exc,
  input  wire logic             integer_overflow_exc,
  input  wire logic             data_address_error,
  input  wire logic             soft_reset_req,
  input  wire logic             data_translation_exc,
  input  wire logic             tlb_modified_exc,
  input  wire logic             data_parity_error,
  input  wire logic             watch_exc,
  input  wire logic             data_bus_error,
  input  wire logic             instr_tlb_miss,
  input  wire logic             instr_cache_miss,
  input  wire logic             data_tlb_miss,
  input  wire logic             data_cache_miss,
  input  wire logic             victim_dirty,
  input  wire logic             refill_last_word,
  input  wire logic             cache_op_busy,
  input  wire logic             rr_nullified,
  input  wire logic             rr_uses_dcache,
  input  wire logic             rr_is_load,
  input  wire logic             rr_is_mfhilo,
  input  wire logic             muldiv_busy,
  input  wire logic             ex_is_load,
  input  wire logic             ex_is_mfsys,
  input  wire logic             ex_is_mfhilo,
  input  wire logic             ex_is_store,
  input  wire logic             ex_is_cfg_write,
  input  wire logic             ex_writes,
  input  wire logic             dc_writes,
  input  wire logic             dc_is_store,
  input  wire logic             dc_is_cache_op,
  input  wire pic_pkg::pic_reg_t rr_src_a,
  input  wire pic_pkg::pic_reg_t rr_src_b,
  input  wire pic_pkg::pic_reg_t ex_dst,
  input  wire pic_pkg::pic_reg_t dc_dst,
  input  wire pic_pkg::pic_reg_t wb_dst,
  input  wire logic             wb_writes,
  output logic                  pipe_hold,
  output logic                  rr_hold,
  output logic                  ex_bubble,
  output logic                  instr_tlb_miss_stall,
  output logic                  instr_cache_miss_stall,
  output logic                  data_tlb_miss_stall,
  output logic                  data_cache_miss_stall,
  output logic                  data_cache_busy_stall,
  output logic                  load_use_slip,
  output logic                  muldiv_busy_slip,
  output logic                  store_then_load_slip,
  output logic                  sysctl_slip,
  output logic                  victim_to_wbuf,
  output logic [3:0]            kill_stage,
  output logic                  exc_commit,
  output pic_pkg::pic_exc_t     exc_code,
  output logic                  exc_redirect,
  output logic                  arch_write_en,
  output pic_pkg::pic_byp_t     byp_sel_a,
  output pic_pkg::pic_byp_t     byp_sel_b,
  output pic_pkg::pic_reg_t     rf_raddr_a,
  output pic_pkg::pic_reg_t     rf_raddr_b,
  output pic_pkg::pic_reg_t     rf_waddr,
  output pic_pkg::pic_mode_t    pipe_mode
);
  import pic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // exception flags carried down the pipe
  logic     ex_flag;
  logic     dc_flag;
  logic     wb_flag;
  pic_exc_t ex_code;
  pic_exc_t dc_code;
  pic_exc_t wb_code;
  logic     rr_live;
  logic     ex_live;
  logic     dc_live;
  logic     wb_live;
  logic     store_busy;
  logic     miss_active;
  logic     slip_q;
  logic     cfg_q;
  logic     rr_flag;

  // per stage detection, fixed priority inside a stage
  wire f_exc  = fetch_valid & fetch_address_error;
  wire r_exc  = rr_live & (nmi_req | fetch_translation_exc |
                fetch_parity_error | external_interrupt |
                fetch_bus_error | system_call_exc | breakpoint_exc |
                coproc_unusable_exc | reserved_instr_exc);
  wire e_exc  = ex_live & (trap_exc | integer_overflow_exc |
                data_address_error);
  wire d_exc  = dc_live & (soft_reset_req | data_translation_exc |
                tlb_modified_exc | data_parity_error | watch_exc |
                data_bus_error);

  wire pic_exc_t r_code = nmi_req ? `PIC_EXC_NMI :
                          fetch_translation_exc ? `PIC_EXC_TLB_I :
                          fetch_parity_error ? `PIC_EXC_PARITY :
                          external_interrupt ? `PIC_EXC_INT :
                          fetch_bus_error ? `PIC_EXC_BUS_I :
                          system_call_exc ? `PIC_EXC_SYSCALL :
                          breakpoint_exc ? `PIC_EXC_BREAK :
                          coproc_unusable_exc ? `PIC_EXC_COPU :
                          `PIC_EXC_RESERVED_INSTR_EXC;
  wire pic_exc_t e_code = trap_exc ? `PIC_EXC_TRAP :
                          integer_overflow_exc ? `PIC_EXC_OVF :
                          `PIC_EXC_ADDR_ERR_D;
  wire pic_exc_t d_code = soft_reset_req ? `PIC_EXC_RESET :
                          data_translation_exc ? `PIC_EXC_TLB_D :
                          tlb_modified_exc ? `PIC_EXC_TLB_MOD :
                          data_parity_error ? `PIC_EXC_PARITY :
                          watch_exc ? `PIC_EXC_WATCH :
                          `PIC_EXC_BUS_D;

  // oldest flagged instruction kills itself and everything younger
  wire dc_fault = dc_live & (dc_flag | d_exc);
  wire ex_fault = ex_live & (ex_flag | e_exc);
  wire commit   = wb_live & wb_flag;
  wire kill_dc  = commit;
  wire kill_ex  = commit | dc_fault;
  wire kill_rr  = kill_ex | ex_fault;
  wire kill_f   = kill_rr | r_exc | (rr_live & rr_flag);

  ////////////////////////////////////////////////////////////////////////
  // stalls, masked for killed instructions
  wire s_itm = rr_live & ~kill_rr & instr_tlb_miss;
  wire s_icm = rr_live & ~kill_rr & instr_cache_miss;
  wire s_dtm = dc_live & ~kill_dc & data_tlb_miss;
  wire s_dcm = dc_live & ~kill_dc & (data_cache_miss | miss_active)
               & ~refill_last_word;
  wire s_cop = dc_live & ~kill_dc & dc_is_cache_op
               & cache_op_busy;
  wire s_dcb = (store_busy & rr_live & ~kill_rr & rr_uses_dcache)
               | s_cop;
  wire stall = s_itm | s_icm | s_dtm | s_dcm | s_dcb;

  ////////////////////////////////////////////////////////////////////////
  // slips: only live, unkilled register-read instruction
  wire rr_ok   = rr_live & ~rr_nullified & ~kill_rr;
  wire hit_a_e = ex_writes & (ex_dst == rr_src_a) & (ex_dst != '0);
  wire hit_b_e = ex_writes & (ex_dst == rr_src_b) & (ex_dst != '0);
  wire hit_a_d = dc_writes & (dc_dst == rr_src_a) & (dc_dst != '0);
  wire hit_b_d = dc_writes & (dc_dst == rr_src_b) & (dc_dst != '0);
  wire ex_late = ex_live & (ex_is_load | ex_is_mfsys | ex_is_mfhilo);
  wire p_ldi   = rr_ok & ex_late & (hit_a_e | hit_b_e);
  wire p_mdi   = rr_ok & rr_is_mfhilo & muldiv_busy;
  wire p_sli   = rr_ok & rr_is_load & ex_live & ex_is_store
                 & ~slip_q;
  wire p_cp0   = rr_ok & ex_live & ex_is_cfg_write & ~cfg_q;
  wire slip    = ~stall & (p_ldi | p_mdi | p_sli | p_cp0);

  ////////////////////////////////////////////////////////////////////////
  // bypass selection into register-read only
  assign byp_sel_a = hit_a_e ? `PIC_BYP_EX :
                     hit_a_d ? `PIC_BYP_DC : `PIC_BYP_FILE;
  assign byp_sel_b = hit_b_e ? `PIC_BYP_EX :
                     hit_b_d ? `PIC_BYP_DC : `PIC_BYP_FILE;
  assign rf_raddr_a = rr_src_a;
  assign rf_raddr_b = rr_src_b;
  assign rf_waddr   = wb_dst;

  ////////////////////////////////////////////////////////////////////////
  // status outputs
  assign pipe_hold   = stall;
  assign rr_hold     = stall | slip;
  assign ex_bubble   = slip | kill_rr;
  assign instr_tlb_miss_stall   = s_itm;
  assign instr_cache_miss_stall = s_icm;
  assign data_tlb_miss_stall    = s_dtm;
  assign data_cache_miss_stall  = s_dcm;
  assign data_cache_busy_stall  = s_dcb;
  assign load_use_slip          = slip & p_ldi;
  assign muldiv_busy_slip       = slip & p_mdi;
  assign store_then_load_slip   = slip & p_sli;
  assign sysctl_slip            = slip & p_cp0;
  assign kill_stage    = {kill_dc, kill_ex, kill_rr, kill_f};
  assign exc_commit    = commit & ~stall;
  assign exc_code      = wb_code;
  assign exc_redirect  = commit & ~stall;
  assign arch_write_en = wb_live & ~wb_flag & wb_writes
                         & ~stall;
  assign pipe_mode     = stall ? PIC_STALL : slip ? PIC_SLIP : PIC_RUN;

  ////////////////////////////////////////////////////////////////////////
  // stage occupancy and flag pipeline, advanced only when not stalled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rr_live <= 1'b0;
      ex_live <= 1'b0;
      dc_live <= 1'b0;
      wb_live <= 1'b0;
      ex_flag <= 1'b0;
      dc_flag <= 1'b0;
      wb_flag <= 1'b0;
      ex_code <= '0;
      dc_code <= '0;
      wb_code <= '0;
    end else if (!stall) begin
      wb_live <= dc_live & ~kill_dc;
      wb_flag <= dc_fault & ~kill_dc;
      wb_code <= dc_flag ? dc_code : d_code;
      dc_live <= ex_live & ~kill_ex;
      dc_flag <= ex_fault & ~kill_ex;
      dc_code <= ex_flag ? ex_code : e_code;
      if (!slip) begin
        ex_live <= rr_live & ~kill_rr;
        ex_flag <= (r_exc | rr_flag) & ~kill_rr;
        ex_code <= rr_flag ? `PIC_EXC_ADDR_ERR_F : r_code;
        rr_live <= fetch_valid & ~kill_f;
      end else begin
        ex_live <= 1'b0;
        ex_flag <= 1'b0;
        if (kill_rr) rr_live <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rr_flag <= 1'b0;
    end else if (!stall && !slip) begin
      rr_flag <= f_exc & ~kill_f;
    end else if (kill_rr) begin
      rr_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // miss, write buffer and one-clock slip bookkeeping
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      miss_active    <= 1'b0;
      victim_to_wbuf <= 1'b0;
      store_busy     <= 1'b0;
      slip_q         <= 1'b0;
      cfg_q          <= 1'b0;
    end else begin
      miss_active    <= s_dcm;
      victim_to_wbuf <= dc_live & data_cache_miss & victim_dirty
                        & ~miss_active;
      store_busy     <= ~stall & dc_live & dc_is_store
                        & ~kill_dc;
      slip_q         <= slip & p_sli;
      cfg_q          <= slip & p_cp0;
    end
  end

  a_stall_holds: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    stall |=> $stable(wb_live) && $stable(dc_live))
    else $error("stage moved during stall");
  a_slip_bubble: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    slip |=> !ex_live)
    else $error("no bubble after slip");
  a_sli_one: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    store_then_load_slip |=> !store_then_load_slip)
    else $error("store-load slip over one clock");
  a_cp0_one: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sysctl_slip |=> !sysctl_slip)
    else $error("sysctl slip over one clock");
  a_kill_order: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    kill_stage[2] |-> kill_stage[1] && kill_stage[0])
    else $error("younger stage not killed");
  a_no_arch_wr: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    stall |-> !arch_write_en && !exc_commit)
    else $error("state updated in stall");
  a_killed_slip: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (kill_rr || rr_nullified) |-> !load_use_slip && !muldiv_busy_slip)
    else $error("killed instruction slipped");
  a_victim_move: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (dc_live && data_cache_miss && victim_dirty && !miss_active)
      |=> victim_to_wbuf)
    else $error("dirty victim not moved");
  a_refill_end: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    refill_last_word |-> !data_cache_miss_stall)
    else $error("stall after last refill word");
  a_byp_ex: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (ex_writes && ex_dst == rr_src_a && ex_dst != '0)
      |-> byp_sel_a == `PIC_BYP_EX)
    else $error("bypass not from execute");
endmodule

// File: tb/pic_far_model.sv
// far side model: data cache refill, mul/div unit, cache op engine
// assumes go pulses from the bench, one clk_sys domain
`timescale 1ns/100ps
module pic_far_model #(
  parameter int REFILL_WORDS = 4,
  parameter int MD_CYCLES    = 6,
  parameter int OP_CYCLES    = 5
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic miss_go,
  input  wire logic md_go,
  input  wire logic op_go,
  output logic      data_cache_miss,
  output logic      refill_last_word,
  output logic      muldiv_busy,
  output logic      cache_op_busy
);
  logic [7:0] miss_cnt;
  logic [7:0] md_cnt;
  logic [7:0] op_cnt;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      miss_cnt <= 8'h00;
      md_cnt   <= 8'h00;
      op_cnt   <= 8'h00;
    end else begin
      miss_cnt <= miss_go ? 8'(REFILL_WORDS) : miss_cnt - 8'(miss_cnt != 0);
      md_cnt   <= md_go ? 8'(MD_CYCLES) : md_cnt - 8'(md_cnt != 0);
      op_cnt   <= op_go ? 8'(OP_CYCLES) : op_cnt - 8'(op_cnt != 0);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  assign data_cache_miss  = miss_cnt != 8'h00;
  assign refill_last_word = miss_cnt == 8'h01;
  assign muldiv_busy      = md_cnt != 8'h00;
  assign cache_op_busy    = op_cnt != 8'h00;
endmodule

// File: tb/tb.sv
// self-checking bench for the pipeline interlock and exception control
// assumes pic_far_model stands in for the data cache and the mul/div unit
`timescale 1ns/100ps
`include "pic_consts.svh"
module tb;
  import pic_pkg::*;
  logic clk_sys, reset_n, fetch_valid, rr_valid, victim_dirty, wb_writes;
  logic [18:0] exc_in;
  logic instr_tlb_miss, instr_cache_miss, data_tlb_miss, rr_nullified;
  logic rr_uses_dcache, rr_is_load, rr_is_mfhilo, ex_is_load, ex_is_mfsys;
  logic ex_is_mfhilo, ex_is_store, ex_is_cfg_write, ex_writes, dc_writes;
  logic dc_is_store, dc_is_cache_op, miss_go, md_go, op_go;
  logic data_cache_miss, refill_last_word, muldiv_busy, cache_op_busy;
  logic pipe_hold, rr_hold, ex_bubble, load_use_slip, muldiv_busy_slip;
  logic store_then_load_slip, sysctl_slip, victim_to_wbuf, exc_commit;
  logic exc_redirect, arch_write_en, m1, m2;
  logic [3:0] kill_stage;
  logic [4:0] stall_why;
  pic_reg_t rr_src_a, rr_src_b, ex_dst, dc_dst, wb_dst;
  pic_reg_t rf_raddr_a, rf_raddr_b, rf_waddr;
  pic_exc_t exc_code;
  pic_byp_t byp_sel_a, byp_sel_b;
  pic_mode_t pipe_mode;
  pic_exc_t exp_q[$];
  pic_exc_t codes [19] = '{`PIC_EXC_ADDR_ERR_F, `PIC_EXC_NMI, `PIC_EXC_TLB_I,
    `PIC_EXC_PARITY, `PIC_EXC_INT, `PIC_EXC_BUS_I, `PIC_EXC_SYSCALL,
    `PIC_EXC_BREAK, `PIC_EXC_COPU, `PIC_EXC_RESERVED_INSTR_EXC, `PIC_EXC_TRAP,
    `PIC_EXC_OVF, `PIC_EXC_ADDR_ERR_D, `PIC_EXC_RESET, `PIC_EXC_TLB_D,
    `PIC_EXC_TLB_MOD, `PIC_EXC_PARITY, `PIC_EXC_WATCH, `PIC_EXC_BUS_D};
  logic [2:0] slip_exp [6] = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h1, 3'h0};
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int ra, rb;
  ////////////////////////////////////////////////////////////////////////
  pic_ctrl u_pic_ctrl (.clk_sys, .reset_n, .fetch_valid, .rr_valid,
    .fetch_address_error(exc_in[0]), .nmi_req(exc_in[1]),
    .fetch_translation_exc(exc_in[2]), .fetch_parity_error(exc_in[3]),
    .external_interrupt(exc_in[4]), .fetch_bus_error(exc_in[5]),
    .system_call_exc(exc_in[6]), .breakpoint_exc(exc_in[7]),
    .coproc_unusable_exc(exc_in[8]), .reserved_instr_exc(exc_in[9]),
    .trap_exc(exc_in[10]), .integer_overflow_exc(exc_in[11]),
    .data_address_error(exc_in[12]), .soft_reset_req(exc_in[13]),
    .data_translation_exc(exc_in[14]), .tlb_modified_exc(exc_in[15]),
    .data_parity_error(exc_in[16]), .watch_exc(exc_in[17]),
    .data_bus_error(exc_in[18]), .instr_tlb_miss, .instr_cache_miss,
    .data_tlb_miss, .data_cache_miss, .victim_dirty, .refill_last_word,
    .cache_op_busy, .rr_nullified, .rr_uses_dcache, .rr_is_load,
    .rr_is_mfhilo, .muldiv_busy, .ex_is_load, .ex_is_mfsys, .ex_is_mfhilo,
    .ex_is_store, .ex_is_cfg_write, .ex_writes, .dc_writes, .dc_is_store,
    .dc_is_cache_op, .rr_src_a, .rr_src_b, .ex_dst, .dc_dst, .wb_dst,
    .wb_writes, .pipe_hold, .rr_hold, .ex_bubble,
    .instr_tlb_miss_stall(stall_why[4]),
    .instr_cache_miss_stall(stall_why[3]),
    .data_tlb_miss_stall(stall_why[2]), .data_cache_miss_stall(stall_why[1]),
    .data_cache_busy_stall(stall_why[0]), .load_use_slip,
    .muldiv_busy_slip, .store_then_load_slip, .sysctl_slip, .victim_to_wbuf,
    .kill_stage, .exc_commit, .exc_code, .exc_redirect, .arch_write_en,
    .byp_sel_a, .byp_sel_b, .rf_raddr_a, .rf_raddr_b, .rf_waddr, .pipe_mode);
  pic_far_model u_pic_far_model (.clk_sys, .reset_n, .miss_go, .md_go,
    .op_go, .data_cache_miss, .refill_last_word, .muldiv_busy,
    .cache_op_busy);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic clr();
    {instr_tlb_miss, instr_cache_miss, data_tlb_miss, rr_nullified} = '0;
    {rr_uses_dcache, rr_is_load, rr_is_mfhilo, ex_is_load, ex_is_mfsys} = '0;
    {ex_is_mfhilo, ex_is_store, ex_is_cfg_write, ex_writes, dc_writes} = '0;
    {dc_is_store, dc_is_cache_op, miss_go, md_go, op_go, victim_dirty} = '0;
    {rr_src_a, rr_src_b, ex_dst, dc_dst, wb_dst, exc_in} = '0;
    wb_writes = 1'b1;
  endtask
  // slip cases: load, move-from sysctl, move-from hi/lo, store-load,
  // config write, killed instruction; one free cycle refills execute
  task automatic slip(input int k);
    @(negedge clk_sys);
    clr();
    @(negedge clk_sys);
    clr();
    rr_src_a = 5'h07;
    ex_dst = 5'h07;
    ex_writes = (k < 3 || k == 5);
    {ex_is_load, ex_is_mfsys, ex_is_mfhilo} =
      (k < 3) ? 3'(4 >> k) : {k == 5, 2'b00};
    {ex_is_store, rr_is_load} = {2{k == 3}};
    ex_is_cfg_write = (k == 4);
    rr_nullified = (k == 5);
    #1;
    check({load_use_slip, store_then_load_slip, sysctl_slip},
          slip_exp[k]);
    check(rr_hold, k != 5);
    check(pipe_hold, 0);
    if (k != 5)
      check({ex_bubble, pipe_mode}, {1'b1, PIC_SLIP});
  endtask
  // stall cases: mul/div slip, cache op, dirty miss, two front stalls and a data TLB stall,
  // then a store followed by a data cache user
  task automatic watch(input int k);
    @(negedge clk_sys);
    clr();
    {rr_is_mfhilo, md_go} = {2{k == 0}};
    {dc_is_cache_op, op_go} = {2{k == 1}};
    {victim_dirty, miss_go} = {1'b1, k == 2};
    {dc_is_store, rr_uses_dcache} = {2{k == 6}};
    {m1, m2} = 2'b00;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      {md_go, op_go, miss_go, dc_is_store} = 4'h0;
      {instr_tlb_miss, instr_cache_miss, data_tlb_miss} =
        (i < 3 && k > 2) ? 3'(4 >> (k - 3)) : 3'h0;
      #1;
      case (k)
        0: check(muldiv_busy_slip, muldiv_busy);
        1: check({pipe_hold, pipe_mode == PIC_STALL},
                 {2{cache_op_busy}});
        2: if (!refill_last_word) begin
          check(pipe_hold, data_cache_miss);
          check(arch_write_en, !data_cache_miss);
        end
        6: check(pipe_hold, i == 0);
        default: check(pipe_hold, i < 3);
      endcase
      check(stall_why, {(i < 3 && k > 2) ? 3'(4 >> (k - 3)) : 3'h0,
            k == 2 && data_cache_miss && !refill_last_word,
            (k == 1 && cache_op_busy) || (k == 6 && i == 0)});
      if (k == 2)
        check(victim_to_wbuf, data_cache_miss & m1 & !m2);
      {m2, m1} = {m1, data_cache_miss};
    end
  endtask
  // notes of expected exception codes are taken off here at each commit
  always @(posedge clk_sys) begin
    if (reset_n && exc_commit === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({exc_code, exc_redirect, kill_stage},
                 {exp_q.pop_front(), 1'b1, 4'hf});
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    fetch_valid = 1'b1;
    rr_valid = 1'b1;
    clr();
    void'($urandom(32'h3b7a));
    repeat (10) @(negedge clk_sys);
    check({pipe_hold, exc_commit, kill_stage, pipe_mode},
          PIC_RUN);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    for (int n = 0; n < 8; n++) begin
      @(negedge clk_sys);
      clr();
      ra = (n == 0) ? 0 : $urandom_range(31, 0);
      rb = $urandom_range(31, 0);
      {rr_src_a, ex_dst, rr_src_b, dc_dst} = {ra[4:0], ra[4:0], {2{rb[4:0]}}};
      {ex_writes, dc_writes, wb_dst} = {2'b11, 5'(ra ^ rb)};
      #1;
      check(byp_sel_a, ra == 0 ? `PIC_BYP_FILE : `PIC_BYP_EX);
      check(byp_sel_b, rb == 0 ? `PIC_BYP_FILE :
            (rb == ra ? `PIC_BYP_EX : `PIC_BYP_DC));
      check({rf_raddr_a, rf_raddr_b, rf_waddr},
            {rr_src_a, rr_src_b, wb_dst});
    end
    for (int k = 0; k < 6; k++) slip(k);
    for (int k = 0; k < 7; k++) watch(k);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      clr();
      exc_in = (i < 19) ? 19'(1 << i) : 19'h00600;
      exp_q.push_back(i < 19 ? codes[i] : pic_exc_t'(`PIC_EXC_TRAP));
      #1;
      if (i == 9) check(kill_stage[1:0], 2'h1);
      if (i == 19) check(kill_stage[2:0], 3'h3);
      @(negedge clk_sys);
      exc_in = '0;
      repeat (8) @(negedge clk_sys);
      check(exp_q.size(), 0);
    end
    complete_run();
  end
endmodule
